/* File: logic/spi_port_pkg.sv */
// constants, types and decode helpers for the sensor spi register port
// assumes one 40 mhz system clock; spi pins arrive asynchronous to it
// Notes on behaviour
// - port acts only while chip select low
// - miso is output, mosi sampled input
// - default mode: clock idles high, rising sample
// - read data follows a register-dependent fetch delay
// - fetch done within 1.5 us in configuration
// - fetch may take 4.5 us while capturing
// - ready pin low fetching, high when ready
// - ready pin off after reset, enabled by software
// - every write lands in shadow copy first
// - shadow commits at frame start or state entry
// - reads of writable registers return the shadow copy
// - setup-only write waits for setup pass
// - writes honour per-register state permission class
// - standby accepts only two registers
// - feedback registers are read-only status
package spi_port_pkg;

   localparam int CLK_MHZ = 40;
   localparam int FETCH_CFG_NS = 1500;
   localparam int FETCH_RUN_NS = 4500;
   // longest times round down
   localparam int FETCH_CFG_CYC = (FETCH_CFG_NS * CLK_MHZ) / 1000;
   localparam int FETCH_RUN_CYC = (FETCH_RUN_NS * CLK_MHZ) / 1000;
   localparam int FETCH_W = 8;
   localparam logic [FETCH_W-1:0] FETCH_CFG = FETCH_CFG_CYC[FETCH_W-1:0];
   localparam logic [FETCH_W-1:0] FETCH_RUN = FETCH_RUN_CYC[FETCH_W-1:0];
   localparam logic [FETCH_W-1:0] FETCH_FAST = 8'h01;

   localparam int WORD_W = 16;
   localparam int BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] WORD_BITS = 5'h10;
   localparam int WRITE_FLAG_BIT = 0;
   localparam int HANDSHAKE_EN_BIT = 0;

   localparam logic [15:0] ADDR_CONFIG1 = 16'h01d0;
   localparam logic [15:0] ADDR_LINE_LENGTH = 16'h0200;
   localparam logic [15:0] ADDR_TEMP_FB = 16'h0710;
   localparam logic [15:0] ADDR_GENERAL_FB = 16'h0718;
   localparam logic [15:0] ADDR_CLAMP_A = 16'h2478;
   localparam logic [15:0] ADDR_SET_STATE = 16'h4018;
   localparam logic [15:0] ADDR_HANDSHAKE = 16'h4040;
   localparam logic [15:0] ADDR_SOFT_RESET = 16'h4060;

   localparam logic [15:0] RST_CONFIG1 = 16'hfc10;
   localparam logic [15:0] RST_LINE_LENGTH = 16'h0578;
   localparam logic [15:0] RST_CLAMP_A = 16'h10b8;
   localparam logic [15:0] RST_ZERO = 16'h0000;

   localparam int NUM_SLOTS = 6;
   localparam int SLOT_W = 3;
   localparam logic [SLOT_W-1:0] SLOT_CONFIG1 = 3'h0;
   localparam logic [SLOT_W-1:0] SLOT_LINE_LENGTH = 3'h1;
   localparam logic [SLOT_W-1:0] SLOT_CLAMP_A = 3'h2;
   localparam logic [SLOT_W-1:0] SLOT_SET_STATE = 3'h3;
   localparam logic [SLOT_W-1:0] SLOT_HANDSHAKE = 3'h4;
   localparam logic [SLOT_W-1:0] SLOT_SOFT_RESET = 3'h5;

   typedef enum logic [1:0] {STANDBY_STATE, IDLE_STATE, CONFIG_STATE, CAPTURE_ACTIVE_STATE} sensor_state_t;
   typedef enum logic [2:0] {ACC_ANY, ACC_CFG_IDLE, ACC_CFG_ONLY, ACC_FEEDBACK, ACC_NONE} access_class_t;

   typedef struct packed {
      logic valid;
      logic [WORD_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } reg_write_t;

   typedef struct packed {
      logic [WORD_W-1:0] config1;
      logic [WORD_W-1:0] line_length;
      logic [WORD_W-1:0] clamp_a;
      logic [WORD_W-1:0] set_state;
      logic [WORD_W-1:0] readback_handshake;
      logic [WORD_W-1:0] soft_reset;
   } active_regs_t;

   function automatic access_class_t class_of(input logic [WORD_W-1:0] addr);
      case (addr)
         ADDR_CONFIG1: class_of = ACC_CFG_ONLY;
         ADDR_LINE_LENGTH, ADDR_HANDSHAKE, ADDR_SOFT_RESET: class_of = ACC_CFG_IDLE;
         ADDR_CLAMP_A, ADDR_SET_STATE: class_of = ACC_ANY;
         ADDR_TEMP_FB, ADDR_GENERAL_FB: class_of = ACC_FEEDBACK;
         default: class_of = ACC_NONE;
      endcase
   endfunction : class_of

   function automatic logic [SLOT_W-1:0] slot_of(input logic [WORD_W-1:0] addr);
      case (addr)
         ADDR_LINE_LENGTH: slot_of = SLOT_LINE_LENGTH;
         ADDR_CLAMP_A: slot_of = SLOT_CLAMP_A;
         ADDR_SET_STATE: slot_of = SLOT_SET_STATE;
         ADDR_HANDSHAKE: slot_of = SLOT_HANDSHAKE;
         ADDR_SOFT_RESET: slot_of = SLOT_SOFT_RESET;
         default: slot_of = SLOT_CONFIG1;
      endcase
   endfunction : slot_of

   function automatic logic [WORD_W-1:0] reset_of(input int slot);
      case (slot)
         0: reset_of = RST_CONFIG1;
         1: reset_of = RST_LINE_LENGTH;
         2: reset_of = RST_CLAMP_A;
         default: reset_of = RST_ZERO;
      endcase
   endfunction : reset_of

endpackage : spi_port_pkg

/* File: logic/reg_store.sv */
// shadow and active copies of the writable registers
// assumes write requests and sensor state on the same clock as this module
`timescale 1ns/1ps
module reg_store
   import spi_port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire reg_write_t wr_i,
   input wire logic [WORD_W-1:0] rd_addr_i,
   output logic [WORD_W-1:0] rd_data_o,
   input wire sensor_state_t sensor_state_i,
   input wire logic frame_start_i,
   output active_regs_t active_o
);

   logic [WORD_W-1:0] shadow [NUM_SLOTS];
   logic [WORD_W-1:0] active [NUM_SLOTS];
   logic [WORD_W-1:0] next_shadow [NUM_SLOTS];
   logic [WORD_W-1:0] next_active [NUM_SLOTS];
   sensor_state_t state_q;
   logic wr_ok;
   logic state_changed;
   access_class_t wr_class;

   // slot index back to its bus address, used to find each slot's class
   function automatic logic [WORD_W-1:0] addr_of(input int slot);
      case (slot)
         0: addr_of = ADDR_CONFIG1;
         1: addr_of = ADDR_LINE_LENGTH;
         2: addr_of = ADDR_CLAMP_A;
         3: addr_of = ADDR_SET_STATE;
         4: addr_of = ADDR_HANDSHAKE;
         default: addr_of = ADDR_SOFT_RESET;
      endcase
   endfunction : addr_of

   // permission check; illegal writes are dropped silently
   always_comb begin
      wr_class = class_of(wr_i.addr);
      state_changed = (sensor_state_i != state_q);
      if (sensor_state_i == STANDBY_STATE) begin
         wr_ok = (wr_i.addr == ADDR_SET_STATE) || (wr_i.addr == ADDR_SOFT_RESET);
      end else begin
         case (wr_class)
            ACC_ANY: wr_ok = 1'b1;
            // capture writes are kept in shadow for the next setup pass
            ACC_CFG_IDLE: wr_ok = 1'b1;
            ACC_CFG_ONLY: wr_ok = (sensor_state_i == CONFIG_STATE) || (sensor_state_i == CAPTURE_ACTIVE_STATE);
            default: wr_ok = 1'b0;
         endcase
      end
   end

   // writes go to shadow; commit copies shadow to active per class
   always_comb begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
         next_shadow[i] = shadow[i];
         next_active[i] = active[i];
         if (wr_i.valid && wr_ok && (slot_of(wr_i.addr) == i[SLOT_W-1:0])) begin
            next_shadow[i] = wr_i.data;
         end
      end
      // any-state registers follow each frame or state change
      for (int i = 0; i < NUM_SLOTS; i++) begin
         if (frame_start_i || state_changed) begin
            case (class_of(addr_of(i)))
               ACC_ANY: next_active[i] = shadow[i];
               ACC_CFG_ONLY: begin
                  // config-only values commit in configuration alone
                  if (sensor_state_i == CONFIG_STATE) begin
                     next_active[i] = shadow[i];
                  end
               end
               default: begin
                  // setup-only values never move while capturing
                  if ((sensor_state_i == CONFIG_STATE) || (sensor_state_i == IDLE_STATE)) begin
                     next_active[i] = shadow[i];
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_q <= CONFIG_STATE;
         for (int i = 0; i < NUM_SLOTS; i++) begin
            shadow[i] <= reset_of(i);
            active[i] <= reset_of(i);
         end
      end else begin
         state_q <= sensor_state_i;
         shadow <= next_shadow;
         active <= next_active;
      end
   end

   // readback sees the value about to be applied
   assign rd_data_o = shadow[slot_of(rd_addr_i)];
   assign active_o.config1 = active[SLOT_CONFIG1];
   assign active_o.line_length = active[SLOT_LINE_LENGTH];
   assign active_o.clamp_a = active[SLOT_CLAMP_A];
   assign active_o.set_state = active[SLOT_SET_STATE];
   assign active_o.readback_handshake = active[SLOT_HANDSHAKE];
   assign active_o.soft_reset = active[SLOT_SOFT_RESET];

endmodule : reg_store

/* File: logic/sensor_spi_register_port.sv */
// spi slave register port of the image sensor, mode 3 (clock idle high)
// assumes sck, csn and mosi asynchronous; sck well below clk_i / 4
`timescale 1ns/1ps
module sensor_spi_register_port
   import spi_port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic csn_b_i,
   input wire logic sck_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   output logic readback_ready_out_o,
   input wire sensor_state_t sensor_state_i,
   input wire logic frame_start_i,
   input wire logic [WORD_W-1:0] temp_fb_i,
   input wire logic [WORD_W-1:0] general_fb_i,
   output active_regs_t active_o
);

   typedef enum {ST_IDLE, ST_ADDR, ST_FETCH, ST_WR_DATA, ST_RD_DATA, ST_DONE} port_state_t;

   // two-stage synchronisers, then one more stage for edges
   logic [1:0] csn_sync;
   logic [1:0] sck_sync;
   logic [1:0] mosi_sync;
   logic sck_q;
   logic sck_rise;
   logic sck_fall;
   logic selected;

   port_state_t state;
   port_state_t next_state;
   logic [BIT_CNT_W-1:0] bit_cnt;
   logic [BIT_CNT_W-1:0] next_bit_cnt;
   logic [WORD_W-1:0] rx_shift;
   logic [WORD_W-1:0] next_rx_shift;
   logic [WORD_W-1:0] tx_shift;
   logic [WORD_W-1:0] next_tx_shift;
   logic [WORD_W-1:0] addr;
   logic [WORD_W-1:0] next_addr;
   logic [FETCH_W-1:0] fetch_cnt;
   logic [FETCH_W-1:0] next_fetch_cnt;
   logic miso;
   logic next_miso;
   logic ready;
   logic next_ready;
   reg_write_t wr;
   reg_write_t next_wr;

   logic [WORD_W-1:0] shift_in;
   logic [WORD_W-1:0] shadow_rd;
   logic [WORD_W-1:0] rd_value;
   logic [FETCH_W-1:0] fetch_len;
   logic handshake_en;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         csn_sync <= 2'h3;
         sck_sync <= 2'h3; // clock idles high
         mosi_sync <= 2'h0;
         sck_q <= 1'b1;
      end else begin
         csn_sync <= {csn_sync[0], csn_b_i};
         sck_sync <= {sck_sync[0], sck_i};
         mosi_sync <= {mosi_sync[0], mosi_i};
         sck_q <= sck_sync[1];
      end
   end

   // only the second stages are looked at
   assign selected = !csn_sync[1];
   assign sck_rise = sck_sync[1] && !sck_q;
   assign sck_fall = !sck_sync[1] && sck_q;
   assign shift_in = {rx_shift[WORD_W-2:0], mosi_sync[1]};

   // feedback words come from sensor status, unmapped ones read zero, the rest from shadow
   always_comb begin
      case (class_of(addr))
         ACC_FEEDBACK: rd_value = (addr == ADDR_TEMP_FB) ? temp_fb_i : general_fb_i;
         ACC_NONE: rd_value = RST_ZERO;
         default: rd_value = shadow_rd;
      endcase
   end

   // status words need a slow fetch, worse while capturing
   always_comb begin
      // decoded from the incoming word so no loop runs through next_addr
      if (class_of({shift_in[WORD_W-1:1], 1'b0}) != ACC_FEEDBACK) begin
         fetch_len = FETCH_FAST;
      end else if (sensor_state_i == CAPTURE_ACTIVE_STATE) begin
         fetch_len = FETCH_RUN;
      end else begin
         fetch_len = FETCH_CFG;
      end
   end

   // transaction sequencer
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_rx_shift = rx_shift;
      next_tx_shift = tx_shift;
      next_addr = addr;
      next_fetch_cnt = fetch_cnt;
      next_miso = miso;
      next_ready = ready;
      next_wr = '0;
      if (!selected) begin
         // chip select high aborts any partial word
         next_state = ST_IDLE;
         next_ready = 1'b0;
         next_miso = 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_ADDR;
               next_bit_cnt = '0;
               next_ready = 1'b0;
            end
            ST_ADDR: begin
               if (sck_rise) begin
                  next_rx_shift = shift_in;
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == WORD_BITS - 5'h01) begin
                     next_bit_cnt = '0;
                     next_addr = shift_in;
                     next_addr[WRITE_FLAG_BIT] = 1'b0;
                     if (shift_in[WRITE_FLAG_BIT]) begin
                        next_state = ST_WR_DATA;
                     end else begin
                        next_state = ST_FETCH;
                        next_fetch_cnt = fetch_len;
                     end
                  end
               end
            end
            ST_FETCH: begin
               if (fetch_cnt <= FETCH_FAST) begin
                  next_tx_shift = rd_value;
                  next_ready = 1'b1;
                  next_state = ST_RD_DATA;
               end else begin
                  next_fetch_cnt = fetch_cnt - 8'h01;
               end
            end
            ST_WR_DATA: begin
               if (sck_rise) begin
                  next_rx_shift = shift_in;
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == WORD_BITS - 5'h01) begin
                     next_wr.valid = 1'b1;
                     next_wr.addr = addr;
                     next_wr.data = shift_in;
                     next_state = ST_DONE;
                  end
               end
            end
            ST_RD_DATA: begin
               // leading falling edge launches, master samples on rise
               if (sck_fall) begin
                  next_miso = tx_shift[WORD_W-1];
                  next_tx_shift = {tx_shift[WORD_W-2:0], 1'b0};
               end
               if (sck_rise) begin
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == WORD_BITS - 5'h01) begin
                     next_state = ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               next_state = ST_DONE; // extra clocks ignored until deselect
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state <= ST_IDLE;
         bit_cnt <= '0;
         rx_shift <= '0;
         tx_shift <= '0;
         addr <= '0;
         fetch_cnt <= '0;
         miso <= 1'b0;
         ready <= 1'b0;
         wr <= '0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         rx_shift <= next_rx_shift;
         tx_shift <= next_tx_shift;
         addr <= next_addr;
         fetch_cnt <= next_fetch_cnt;
         miso <= next_miso;
         ready <= next_ready;
         wr <= next_wr;
      end
   end

   reg_store u_store (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .wr_i(wr),
      .rd_addr_i(addr),
      .rd_data_o(shadow_rd),
      .sensor_state_i(sensor_state_i),
      .frame_start_i(frame_start_i),
      .active_o(active_o)
   );

   // handshake pin follows the committed enable, off after reset
   assign handshake_en = active_o.readback_handshake[HANDSHAKE_EN_BIT];
   assign readback_ready_out_o = handshake_en && ready;
   assign miso_o = miso;
   assign miso_oe_o = selected;

endmodule : sensor_spi_register_port

/* File: dv/port_chk_sva.sv */
// assertions for the spi register port, pins of the top module only
// assumes spi pins asynchronous, seen through a two-flop synchroniser
`timescale 1ns/1ps
module port_chk
   import spi_port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic csn_b_i,
   input wire logic sck_i,
   input wire logic miso_o,
   input wire logic miso_oe_o,
   input wire logic readback_ready_out_o,
   input wire sensor_state_t sensor_state_i,
   input wire logic frame_start_i,
   input wire active_regs_t active_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // four samples cover the synchroniser lag on chip select
   oe_idle_a: assert property (csn_b_i [*4] |-> !miso_oe_o)
      else $error("miso enabled while deselected");
   oe_active_a: assert property (!csn_b_i [*4] |-> miso_oe_o)
      else $error("miso not enabled while selected");
   miso_quiet_a: assert property (csn_b_i [*4] |-> !miso_o)
      else $error("miso not low while deselected");
   // read data moves only after a falling serial clock or a deselect
   miso_edge_a: assert property ($changed(miso_o) |-> !$past(sck_i, 2) || $past(csn_b_i, 2))
      else $error("miso changed outside a falling clock");
   ready_off_a: assert property (!active_o.readback_handshake[HANDSHAKE_EN_BIT] |-> !readback_ready_out_o)
      else $error("ready pin high while disabled");
   ready_idle_a: assert property (csn_b_i [*4] |-> !readback_ready_out_o)
      else $error("ready pin high between frames");
   ready_hold_a: assert property (readback_ready_out_o && !csn_b_i && !frame_start_i |=> readback_ready_out_o)
      else $error("ready pin dropped inside a frame");
   // active copy moves only on frame start or state change
   commit_when_a: assert property ($changed(active_o) |->
      $past(frame_start_i) || ($past(sensor_state_i) != $past(sensor_state_i, 2)))
      else $error("active copy changed without commit event");

   cover property ($rose(readback_ready_out_o));
   cover property ($changed(active_o));
   cover property (!csn_b_i && $changed(miso_o));
endmodule : port_chk

bind sensor_spi_register_port port_chk u_chk (.clk_i, .rst_b_i, .csn_b_i, .sck_i, .miso_o, .miso_oe_o,
   .readback_ready_out_o, .sensor_state_i, .frame_start_i, .active_o);

/* File: dv/spi_master_model.sv */
// spi master model for the register port: clock idle high, msb first
// assumes one caller at a time; serial clock stands still between frames
`timescale 1ns/1ps
module spi_master_model (
   output logic csn_b_o,
   output logic sck_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic rdy_i
);
   localparam time HALF = 100ns;
   // idle levels: deselected, clock high
   initial begin
      csn_b_o = 1'b1;
      sck_o = 1'b1;
      mosi_o = 1'b0;
   end

   // drive on the fall, read miso late in the high phase for margin
   task automatic shift(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      for (int i = 15; i > 15 - n; i--) begin
         sck_o = 1'b0;
         mosi_o = w[i];
         #HALF sck_o = 1'b1;
         #(HALF - 5ns) r[i] = miso_i;
         #5ns;
      end
   endtask : shift

   // one frame; reads wait on the ready pin or a fixed worst case
   task automatic xfer(input logic [15:0] a, input logic [15:0] d, input bit hs, input int nd,
         output logic [15:0] r, output int t);
      logic [15:0] unused;
      t = 0;
      #7ns csn_b_o = 1'b0;
      #HALF shift(a, 16, unused);
      if (!a[0] && hs) begin
         while (!rdy_i && t < 6000) begin
            #25ns t += 25;
         end
      end else if (!a[0]) begin
         #5000ns;
      end
      shift(d, nd, r);
      #HALF csn_b_o = 1'b1;
      mosi_o = ~mosi_o; // released line keeps no stale level
      #(2 * HALF);
   endtask : xfer
endmodule : spi_master_model

/* File: dv/tb_sensor_spi_register_port.sv */
// self-checking bench for the sensor spi register port
// assumes the master model owns the spi pins; the bench drives the rest
`timescale 1ns/1ps
module tb_sensor_spi_register_port;
   import spi_port_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic csn_b, sck, mosi, miso_o, miso_oe_o, rdy;
   wire miso_w;
   sensor_state_t st = CONFIG_STATE;
   logic fs = 1'b0;
   logic [15:0] tfb = 16'h0a5c;
   logic [15:0] gfb = 16'h3c96;
   active_regs_t act;
   int error_cnt = 0;
   int compares = 0;
   logic [15:0] r;
   int t;

   always #12.5 clk_i = ~clk_i;
   // miso floats while the port is deselected
   assign miso_w = miso_oe_o ? miso_o : 1'bz;
   sensor_spi_register_port dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .csn_b_i(csn_b), .sck_i(sck),
      .mosi_i(mosi), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .readback_ready_out_o(rdy),
      .sensor_state_i(st), .frame_start_i(fs), .temp_fb_i(tfb), .general_fb_i(gfb), .active_o(act));
   spi_master_model m (.csn_b_o(csn_b), .sck_o(sck), .mosi_o(mosi), .miso_i(miso_w), .rdy_i(rdy));

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      m.xfer(a | 16'h0001, d, 1'b0, 16, r, t);
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [15:0] a, input bit hs);
      m.xfer(a, 16'h0000, hs, 16, r, t);
      @(posedge clk_i);
   endtask : rd
   task automatic go(input sensor_state_t s);
      st <= s;
      repeat (4) @(posedge clk_i);
   endtask : go
   task automatic frame;
      fs <= 1'b1;
      @(posedge clk_i);
      fs <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : frame

   task automatic t_reset;
      chk("ready pin", 16'h0000, {15'h0000, rdy});
      chk("handshake", 16'h0000, act.readback_handshake);
      rd(ADDR_CONFIG1, 1'b0);
      chk("rd config1", RST_CONFIG1, r);
      rd(16'h1230, 1'b0);
      chk("rd unmapped", 16'h0000, r);
      $display("test reset done");
   endtask : t_reset
   task automatic t_shadow;
      go(CAPTURE_ACTIVE_STATE);
      wr(ADDR_LINE_LENGTH, 16'h0640);
      rd(ADDR_LINE_LENGTH, 1'b0);
      chk("rd line_length", 16'h0640, r);
      chk("line_length held", RST_LINE_LENGTH, act.line_length);
      frame();
      chk("line_length frame", RST_LINE_LENGTH, act.line_length);
      go(CONFIG_STATE);
      chk("line_length config", 16'h0640, act.line_length);
      go(CAPTURE_ACTIVE_STATE);
      wr(ADDR_CLAMP_A, 16'h1234);
      chk("clamp held", RST_CLAMP_A, act.clamp_a);
      frame();
      chk("clamp frame", 16'h1234, act.clamp_a);
      $display("test shadow done");
   endtask : t_shadow
   task automatic t_refuse;
      go(IDLE_STATE);
      wr(ADDR_CONFIG1, 16'h1111);
      rd(ADDR_CONFIG1, 1'b0);
      chk("config1 idle", RST_CONFIG1, r);
      go(STANDBY_STATE);
      wr(ADDR_LINE_LENGTH, 16'h0222);
      rd(ADDR_LINE_LENGTH, 1'b0);
      chk("line_length standby", 16'h0640, r);
      wr(ADDR_SET_STATE, 16'h0003);
      rd(ADDR_SET_STATE, 1'b0);
      chk("set_state standby", 16'h0003, r);
      wr(ADDR_SOFT_RESET, 16'h0001);
      go(CONFIG_STATE);
      chk("soft_reset active", 16'h0001, act.soft_reset);
      chk("set_state active", 16'h0003, act.set_state);
      wr(ADDR_CONFIG1, 16'h2222);
      rd(ADDR_CONFIG1, 1'b0);
      chk("config1 config", 16'h2222, r);
      frame();
      chk("config1 active", 16'h2222, act.config1);
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_fetch;
      rd(ADDR_TEMP_FB, 1'b0);
      chk("temp fixed wait", tfb, r);
      go(CAPTURE_ACTIVE_STATE);
      rd(ADDR_GENERAL_FB, 1'b0);
      chk("general fixed wait", gfb, r);
      go(CONFIG_STATE);
      $display("test fetch done");
   endtask : t_fetch
   task automatic t_hand;
      wr(ADDR_HANDSHAKE, 16'h0001);
      chk("enable held", 16'h0000, act.readback_handshake);
      frame();
      chk("enable frame", 16'h0001, act.readback_handshake);
      rd(ADDR_TEMP_FB, 1'b1);
      chk("temp handshake", tfb, r);
      chk("config wait", 16'h0001, 16'(t > 0 && t <= 1700));
      go(CAPTURE_ACTIVE_STATE);
      rd(ADDR_GENERAL_FB, 1'b1);
      chk("general handshake", gfb, r);
      chk("capture wait", 16'h0001, 16'(t > 1700 && t <= 4700));
      chk("ready after frame", 16'h0000, {15'h0000, rdy});
      go(CONFIG_STATE);
      $display("test handshake done");
   endtask : t_hand
   task automatic t_abort;
      // chip select rises after half the data word
      m.xfer(ADDR_CLAMP_A | 16'h0001, 16'hbeef, 1'b0, 8, r, t);
      rd(ADDR_CLAMP_A, 1'b0);
      chk("clamp after abort", 16'h1234, r);
      $display("test abort done");
   endtask : t_abort

   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   // reset, then scenarios in order
   initial begin
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_reset();
      t_shadow();
      t_refuse();
      t_fetch();
      t_hand();
      t_abort();
      complete_run();
   end
   // about 21 frames of up to 12 us each; 1 ms leaves wide margin
   initial begin
      #1ms;
      error_cnt++;
      complete_run();
   end
endmodule : tb_sensor_spi_register_port
